// ### phy_strap_config_autoneg_link.sv
// Strap decoding, auto-negotiation and link establishment for one port.
`timescale 1ns/1ns
module phy_strap_config_autoneg_link #(
    parameter int unsigned LOCK_CYC = phy_cfg_pkg::LINK_LOCK_CYC,
    parameter int unsigned IDLE_WIN_CYC = phy_cfg_pkg::IDLE_WINDOW_CYC,
    parameter int unsigned FLP_SPACE_CYC = phy_cfg_pkg::FLP_SPACING_CYC
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    // Strap pins
    input wire logic media_select_strap_i,
    input wire logic negotiation_enable_strap_i,
    input wire logic rate_select_strap_i,
    input wire logic duplex_select_strap_i,
    input wire logic hw_control_strap_i,
    // Management
    input wire logic mgmt_wr_i,
    input wire logic [1:0] mgmt_wr_sel_i,
    input wire logic [15:0] mgmt_wdata_i,
    input wire logic status_rd_i,
    // Line receive indications
    input wire logic rx_page_valid_i,
    input wire logic [15:0] rx_page_i,
    input wire logic nlp_detect_i,
    input wire logic symbol_valid_i,
    input wire logic symbol_idle_i,
    input wire logic descrambler_lock_i,
    input wire logic link10_good_i,
    // Register contents
    output logic [15:0] ctl_reg_o,
    output logic [15:0] adv_reg_o,
    output logic [15:0] np_tx_reg_o,
    output logic [15:0] lp_base_o,
    output logic [15:0] lp_next_o,
    // Page status
    output logic page_rcvd_o,
    output logic lp_np_able_o,
    output logic base_page_o,
    output logic page_rcvd_ext_o,
    // Link status
    output logic fiber_mode_o,
    output logic link_up_o,
    output logic speed_100_o,
    output logic full_duplex_o,
    output logic aneg_done_o,
    output logic parallel_det_o,
    // Line transmit
    output logic flp_pulse_o
);
    import phy_cfg_pkg::*;

    logic rst_meta;
    logic rst_n;
    logic [4:0] strap_meta;
    logic [4:0] strap_sync;
    logic [4:0] strap_cap;
    logic [1:0] settle_cnt;
    logic captured;
    logic cap_load;
    logic [15:0] def_ctl;
    logic [15:0] def_adv;
    logic [15:0] ctl_reg;
    logic [15:0] adv_reg;
    logic [15:0] np_tx_reg;
    logic sw_rst;
    logic wr_ok;
    logic aneg_en;
    logic aneg_en_q;
    an_state_t state;
    logic [1:0] same_cnt;
    logic [15:0] last_rx;
    logic ack_tx;
    logic [15:0] next_tx_page;
    logic tx_start;
    logic tx_busy;
    logic link_lost;
    logic link_eligible;
    logic [31:0] lock_cnt;
    logic [31:0] win_cnt;
    logic [3:0] run_cnt;
    logic run_seen;
    logic [3:0] common;

    // Reset release is synchronised so all flops leave reset on the same edge.
    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            strap_meta <= 5'h00;
            strap_sync <= 5'h00;
        end
        else
        begin
            strap_meta <= {hw_control_strap_i, media_select_strap_i,
                negotiation_enable_strap_i, rate_select_strap_i, duplex_select_strap_i};
            strap_sync <= strap_meta;
        end
    end

    // Straps are taken once, after the synchroniser has filled with real pin levels.
    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            settle_cnt <= 2'h0;
            captured <= 1'b0;
            cap_load <= 1'b0;
            strap_cap <= 5'h00;
            fiber_mode_o <= 1'b0;
        end
        else
        begin
            cap_load <= 1'b0;
            if (!captured)
            begin
                settle_cnt <= settle_cnt + 2'h1;
                if (settle_cnt == STRAP_SETTLE_CYC - 2'h1)
                begin
                    captured <= 1'b1;
                    cap_load <= 1'b1;
                    strap_cap <= strap_sync;
                    fiber_mode_o <= !strap_sync[3];
                end
            end
        end
    end

    always_comb
    begin
        def_ctl = CTL_RESET_VAL;
        def_adv = ADV_RESET_VAL;
        def_adv[4:0] = SELECTOR_8023;
        if (!strap_cap[3])
        begin
            def_ctl[CTL_SPEED_BIT] = 1'b1;
            def_ctl[CTL_DUPLEX_BIT] = strap_cap[0];
            def_adv[8:5] = 4'hf;
        end
        else if (strap_cap[2])
        begin
            def_ctl[CTL_ANEG_BIT] = 1'b1;
            def_ctl[CTL_SPEED_BIT] = 1'b1;
            def_ctl[CTL_DUPLEX_BIT] = 1'b1;
            case (strap_cap[1:0])
                2'h3: def_adv[8:5] = 4'hf;
                2'h2: def_adv[8:5] = 4'hc;
                2'h1: def_adv[8:5] = 4'h3;
                default: def_adv[8:5] = 4'h5;
            endcase
        end
        else
        begin
            def_ctl[CTL_SPEED_BIT] = strap_cap[1];
            def_ctl[CTL_DUPLEX_BIT] = strap_cap[0];
            def_adv[8:5] = 4'hf;
        end
    end

    assign wr_ok = mgmt_wr_i && captured && !strap_cap[4];

    // A software reset lasts one cycle and reuses the strap values caught at hardware reset.
    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sw_rst <= 1'b0;
        end
        else
        begin
            sw_rst <= wr_ok && (mgmt_wr_sel_i == MGMT_SEL_CTL) && mgmt_wdata_i[CTL_SW_RESET_BIT];
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctl_reg <= CTL_RESET_VAL;
            adv_reg <= ADV_RESET_VAL;
            np_tx_reg <= NP_TX_RESET_VAL;
        end
        else if (cap_load || sw_rst)
        begin
            ctl_reg <= def_ctl;
            adv_reg <= def_adv;
            np_tx_reg <= NP_TX_RESET_VAL;
        end
        else if (wr_ok)
        begin
            case (mgmt_wr_sel_i)
                MGMT_SEL_CTL: ctl_reg <= mgmt_wdata_i & ~(16'h0001 << CTL_SW_RESET_BIT);
                MGMT_SEL_ADV: adv_reg <= mgmt_wdata_i;
                MGMT_SEL_NP_TX: np_tx_reg <= mgmt_wdata_i;
                default: ctl_reg <= ctl_reg;
            endcase
        end
    end

    assign aneg_en = ctl_reg[CTL_ANEG_BIT] && strap_cap[3];
    assign common = adv_reg[8:5] & lp_base_o[8:5];
    assign tx_start = ((state == AN_ABILITY) || (state == AN_NEXT)) && !tx_busy;

    always_comb
    begin
        next_tx_page = adv_reg;
        next_tx_page[PAGE_ACK_BIT] = ack_tx;
        if (state == AN_NEXT)
        begin
            next_tx_page = np_tx_reg;
            next_tx_page[PAGE_ACK_BIT] = 1'b1;
        end
    end

    flp_burst_tx #(
        .SPACING_CYC(FLP_SPACE_CYC),
        .POSITIONS(FLP_POSITIONS)
    ) u_flp_tx (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n),
        .start_i(tx_start),
        .page_i(next_tx_page),
        .pulse_o(flp_pulse_o),
        .busy_o(tx_busy)
    );

    // Negotiation sequence and operating mode.
    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= AN_OFF;
            aneg_en_q <= 1'b0;
            same_cnt <= 2'h0;
            last_rx <= 16'h0000;
            ack_tx <= 1'b0;
            lp_base_o <= 16'h0000;
            lp_next_o <= 16'h0000;
            speed_100_o <= 1'b0;
            full_duplex_o <= 1'b0;
            aneg_done_o <= 1'b0;
            parallel_det_o <= 1'b0;
        end
        else
        begin
            aneg_en_q <= aneg_en;
            if (!aneg_en || sw_rst || cap_load)
            begin
                state <= aneg_en ? AN_START : AN_OFF;
                aneg_done_o <= 1'b0;
                parallel_det_o <= 1'b0;
            end
            else
            begin
                case (state)
                    AN_OFF:
                    begin
                        state <= AN_START;
                    end
                    AN_START:
                    begin
                        same_cnt <= 2'h0;
                        ack_tx <= 1'b0;
                        aneg_done_o <= 1'b0;
                        parallel_det_o <= 1'b0;
                        state <= AN_ABILITY;
                    end
                    AN_ABILITY:
                    begin
                        if (nlp_detect_i)
                        begin
                            speed_100_o <= 1'b0;
                            full_duplex_o <= 1'b0;
                            parallel_det_o <= 1'b1;
                            state <= AN_PARALLEL;
                        end
                        else if (symbol_valid_i && symbol_idle_i)
                        begin
                            speed_100_o <= 1'b1;
                            full_duplex_o <= 1'b0;
                            parallel_det_o <= 1'b1;
                            state <= AN_PARALLEL;
                        end
                        else if (rx_page_valid_i)
                        begin
                            last_rx <= rx_page_i;
                            if (rx_page_i != last_rx || same_cnt == 2'h0)
                            begin
                                same_cnt <= 2'h1;
                            end
                            else if (same_cnt != SAME_PAGES_MIN)
                            begin
                                same_cnt <= same_cnt + 2'h1;
                            end
                            if (rx_page_i == last_rx && same_cnt >= SAME_PAGES_MIN - 2'h1)
                            begin
                                ack_tx <= 1'b1;
                                lp_base_o <= rx_page_i;
                                if (ack_tx && rx_page_i[PAGE_ACK_BIT])
                                begin
                                    if (adv_reg[PAGE_NP_BIT] && rx_page_i[PAGE_NP_BIT])
                                    begin
                                        state <= AN_NEXT;
                                    end
                                    else
                                    begin
                                        state <= AN_DONE;
                                    end
                                end
                            end
                        end
                    end
                    AN_NEXT:
                    begin
                        if (rx_page_valid_i)
                        begin
                            lp_next_o <= rx_page_i;
                            if (!np_tx_reg[PAGE_NP_BIT] && !rx_page_i[PAGE_NP_BIT])
                            begin
                                state <= AN_DONE;
                            end
                        end
                    end
                    AN_DONE:
                    begin
                        aneg_done_o <= 1'b1;
                        speed_100_o <= common[3] || common[2];
                        full_duplex_o <= common[3] || (!common[2] && common[1]);
                        if (link_lost)
                        begin
                            state <= AN_START;
                        end
                    end
                    AN_PARALLEL:
                    begin
                        if (link_lost)
                        begin
                            state <= AN_START;
                        end
                    end
                    default:
                    begin
                        state <= AN_START;
                    end
                endcase
            end
            if (!aneg_en)
            begin
                speed_100_o <= ctl_reg[CTL_SPEED_BIT];
                full_duplex_o <= ctl_reg[CTL_DUPLEX_BIT];
            end
        end
    end

    // Page status flags: a new page in the read cycle keeps the flag set.
    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            page_rcvd_o <= 1'b0;
            page_rcvd_ext_o <= 1'b0;
            lp_np_able_o <= 1'b0;
            base_page_o <= 1'b0;
        end
        else
        begin
            if (status_rd_i)
            begin
                page_rcvd_o <= 1'b0;
                page_rcvd_ext_o <= 1'b0;
                lp_np_able_o <= 1'b0;
            end
            if (state == AN_START)
            begin
                lp_np_able_o <= 1'b0;
                base_page_o <= 1'b0;
            end
            if (rx_page_valid_i && ((state == AN_ABILITY) || (state == AN_NEXT)))
            begin
                page_rcvd_o <= 1'b1;
                page_rcvd_ext_o <= 1'b1;
                base_page_o <= (state == AN_ABILITY);
                if (state == AN_ABILITY && rx_page_i[PAGE_NP_BIT])
                begin
                    lp_np_able_o <= 1'b1;
                end
            end
        end
    end

    assign link_eligible = !aneg_en || (state == AN_DONE) || (state == AN_PARALLEL);

    // Link criteria; the idle window restarts whenever the link is newly up.
    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            link_up_o <= 1'b0;
            link_lost <= 1'b0;
            lock_cnt <= 32'h0;
            win_cnt <= 32'h0;
            run_cnt <= 4'h0;
            run_seen <= 1'b0;
        end
        else
        begin
            link_lost <= 1'b0;
            if (!link_eligible)
            begin
                link_up_o <= 1'b0;
                lock_cnt <= 32'h0;
            end
            else if (!speed_100_o)
            begin
                link_up_o <= link10_good_i;
                link_lost <= link_up_o && !link10_good_i;
            end
            else if (!link_up_o)
            begin
                win_cnt <= 32'h0;
                run_cnt <= 4'h0;
                run_seen <= 1'b0;
                lock_cnt <= descrambler_lock_i ? lock_cnt + 32'h1 : 32'h0;
                if (descrambler_lock_i && lock_cnt == LOCK_CYC - 1)
                begin
                    link_up_o <= 1'b1;
                end
            end
            else
            begin
                if (symbol_valid_i)
                begin
                    run_cnt <= symbol_idle_i ? run_cnt + {3'h0, run_cnt != IDLE_RUN_MIN} : 4'h0;
                end
                if (run_cnt == IDLE_RUN_MIN)
                begin
                    run_seen <= 1'b1;
                end
                if (win_cnt == IDLE_WIN_CYC - 1)
                begin
                    win_cnt <= 32'h0;
                    run_seen <= 1'b0;
                    // A run finished in an earlier window must not keep the link up.
                    run_cnt <= 4'h0;
                    if (!run_seen && run_cnt != IDLE_RUN_MIN)
                    begin
                        link_up_o <= 1'b0;
                        link_lost <= 1'b1;
                        lock_cnt <= 32'h0;
                    end
                end
                else
                begin
                    win_cnt <= win_cnt + 32'h1;
                end
            end
        end
    end

    assign ctl_reg_o = ctl_reg;
    assign adv_reg_o = adv_reg;
    assign np_tx_reg_o = np_tx_reg;

endmodule : phy_strap_config_autoneg_link

// ### phy_cfg_pkg.sv
// Constants, field positions and types shared by the strap, negotiation and link logic.
package phy_cfg_pkg;

    // Clock rate.
    localparam int CLK_PERIOD_NS = 10;

    // Fast link pulse burst timing.
    localparam int FLP_SPACING_NS = 62500;
    localparam int FLP_SPACING_CYC = FLP_SPACING_NS / CLK_PERIOD_NS;
    localparam int FLP_POSITIONS = 33;

    // 100 Mbps link criteria.
    localparam int LINK_LOCK_MS = 50;
    localparam int LINK_LOCK_CYC = LINK_LOCK_MS * 1000000 / CLK_PERIOD_NS;
    localparam int IDLE_WINDOW_MS = 2;
    localparam int IDLE_WINDOW_CYC = IDLE_WINDOW_MS * 1000000 / CLK_PERIOD_NS;
    localparam logic [3:0] IDLE_RUN_MIN = 4'hc;

    // Negotiation and strap settling.
    localparam logic [1:0] SAME_PAGES_MIN = 2'h3;
    localparam logic [1:0] STRAP_SETTLE_CYC = 2'h3;

    // Control word field positions.
    localparam int CTL_SW_RESET_BIT = 15;
    localparam int CTL_SPEED_BIT = 13;
    localparam int CTL_ANEG_BIT = 12;
    localparam int CTL_DUPLEX_BIT = 8;
    localparam logic [15:0] CTL_RESET_VAL = 16'h0000;

    // Advertisement and page field positions.
    localparam int ADV_10H_BIT = 5;
    localparam int ADV_10F_BIT = 6;
    localparam int ADV_100H_BIT = 7;
    localparam int ADV_100F_BIT = 8;
    localparam int PAGE_ACK_BIT = 14;
    localparam int PAGE_NP_BIT = 15;
    localparam logic [4:0] SELECTOR_8023 = 5'h01;
    localparam logic [15:0] ADV_RESET_VAL = 16'h0001;
    localparam logic [15:0] NP_TX_RESET_VAL = 16'h0000;

    // Management write targets.
    localparam logic [1:0] MGMT_SEL_CTL = 2'h0;
    localparam logic [1:0] MGMT_SEL_ADV = 2'h1;
    localparam logic [1:0] MGMT_SEL_NP_TX = 2'h2;

    typedef enum logic [2:0] {
        AN_OFF = 3'h0,
        AN_START = 3'h1,
        AN_ABILITY = 3'h2,
        AN_NEXT = 3'h3,
        AN_DONE = 3'h4,
        AN_PARALLEL = 3'h5
    } an_state_t;

endpackage : phy_cfg_pkg

// ### flp_burst_tx.sv
// Fast link pulse burst generator: one 16-bit page per burst.
`timescale 1ns/1ns
module flp_burst_tx #(
    parameter int unsigned SPACING_CYC = phy_cfg_pkg::FLP_SPACING_CYC,
    parameter int unsigned POSITIONS = phy_cfg_pkg::FLP_POSITIONS
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // Page request
    input wire logic start_i,
    input wire logic [15:0] page_i,
    // Line side
    output logic pulse_o,
    output logic busy_o
);
    logic [5:0] pos;
    logic [31:0] tick;
    logic [15:0] shift;

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            busy_o <= 1'b0;
            pulse_o <= 1'b0;
            pos <= 6'h00;
            tick <= 32'h0;
            shift <= 16'h0000;
        end
        else if (!busy_o)
        begin
            pulse_o <= start_i;
            if (start_i)
            begin
                busy_o <= 1'b1;
                pos <= 6'h00;
                tick <= 32'h0;
                shift <= page_i;
            end
        end
        else if (tick == SPACING_CYC - 1)
        begin
            tick <= 32'h0;
            if (pos == 6'(POSITIONS - 1))
            begin
                busy_o <= 1'b0;
                pulse_o <= 1'b0;
            end
            else
            begin
                pos <= pos + 6'h01;
                // Even positions carry the clock pulse, odd ones a data bit, first bit first.
                if (pos[0])
                begin
                    pulse_o <= 1'b1;
                end
                else
                begin
                    pulse_o <= shift[0];
                    shift <= {1'b0, shift[15:1]};
                end
            end
        end
        else
        begin
            tick <= tick + 32'h1;
            pulse_o <= 1'b0;
        end
    end

endmodule : flp_burst_tx

// ### link_partner.sv
// Remote link partner model: page copies, receive lock and idle symbols.
`timescale 1ns/1ns
module link_partner (
    // Bench control
    input wire logic clk_sys_i,
    input wire logic send_i,
    input wire logic [1:0] copies_i,
    input wire logic [15:0] word_i,
    input wire logic lock_i,
    // Toward the port
    output logic page_valid_o = 1'h0,
    output logic [15:0] page_o = 16'h0000,
    output logic lock_o,
    output logic idle_o
);
    logic [2:0] left = 3'h0;
    always_ff @(posedge clk_sys_i)
    begin
        page_valid_o <= 1'h0;
        // Between pages the bus toggles so a stale word is never mistaken for data.
        page_o <= ~page_o;
        if (send_i)
            left <= {copies_i, 1'h0};
        else if (left != 3'h0)
        begin
            left <= left - 3'h1;
            page_valid_o <= left[0];
            page_o <= left[0] ? word_i : ~page_o;
        end
    end
    assign lock_o = lock_i;
    assign idle_o = lock_i;
endmodule : link_partner

// ### phy_strap_config_autoneg_link_sva.sv
// Concurrent checks on the port's page flags, modes and link timing.
`timescale 1ns/1ns
module phy_link_sva #(
    parameter int unsigned LOCK_CYC = 200
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    // Watched ports
    input wire logic status_rd_i,
    input wire logic rx_page_valid_i,
    input wire logic descrambler_lock_i,
    input wire logic link10_good_i,
    input wire logic page_rcvd_o,
    input wire logic page_rcvd_ext_o,
    input wire logic lp_np_able_o,
    input wire logic fiber_mode_o,
    input wire logic link_up_o,
    input wire logic speed_100_o,
    input wire logic full_duplex_o,
    input wire logic parallel_det_o,
    input wire logic flp_pulse_o
);
    int unsigned lock_run = 0;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!nrst_i);
    always_ff @(posedge clk_sys_i)
        lock_run <= descrambler_lock_i ? lock_run + 1 : 0;
    AST_RD_CLR: assert property (
        status_rd_i && !rx_page_valid_i |=> !page_rcvd_o && !page_rcvd_ext_o)
        else $error("page flags kept after status read");
    AST_NP_CLR: assert property (
        status_rd_i && !rx_page_valid_i |=> !lp_np_able_o)
        else $error("next page flag kept after read");
    AST_PG_HOLD: assert property (
        page_rcvd_o && !status_rd_i |=> page_rcvd_o)
        else $error("page flag lost without read");
    AST_FIBER: assert property (
        fiber_mode_o && $past(fiber_mode_o, 3) |-> speed_100_o)
        else $error("fiber mode not at 100");
    AST_LINK10: assert property (
        link_up_o && !speed_100_o && !$past(speed_100_o) |-> $past(link10_good_i))
        else $error("10 link without integrity");
    AST_PAR_HALF: assert property (
        parallel_det_o && $past(parallel_det_o) |-> !full_duplex_o)
        else $error("parallel link in full duplex");
    AST_LOCK: assert property (
        $rose(link_up_o) && speed_100_o |-> lock_run >= LOCK_CYC - 2)
        else $error("100 link up before lock time");
    AST_FLP: assert property (
        flp_pulse_o |=> !flp_pulse_o [*3])
        else $error("link pulses too close");
endmodule : phy_link_sva
bind phy_strap_config_autoneg_link phy_link_sva #(.LOCK_CYC(LOCK_CYC)) phy_link_sva_i (
    .clk_sys_i, .nrst_i, .status_rd_i, .rx_page_valid_i, .descrambler_lock_i, .link10_good_i,
    .page_rcvd_o, .page_rcvd_ext_o, .lp_np_able_o, .fiber_mode_o, .link_up_o, .speed_100_o,
    .full_duplex_o, .parallel_det_o, .flp_pulse_o);

// ### test_phy_strap_config_autoneg_link.sv
// Self-checking bench for strap decoding, page exchange and link bring-up.
`timescale 1ns/1ns
module test_phy_strap_config_autoneg_link;
    import phy_cfg_pkg::*;
    logic clk_sys_i = 1'h0, nrst_i = 1'h0, hw = 1'h0, wr = 1'h0, rd = 1'h0, nlp = 1'h0, bp;
    logic send = 1'h0, lock = 1'h0, l10 = 1'h0, pv, idle, dlock, pg, fib, up, s100, fd, done, par;
    logic [3:0] strap = 4'hf;
    logic [1:0] sel = 2'h0, copies = 2'h0;
    logic [15:0] wd = 16'h0000, word = 16'h0000, rxp, ctl, adv, lpb;
    int mismatches = 0, n_tests = 0;
    phy_strap_config_autoneg_link #(.LOCK_CYC(200), .IDLE_WIN_CYC(100), .FLP_SPACE_CYC(4))
        phy_strap_config_autoneg_link_i (.clk_sys_i, .nrst_i, .media_select_strap_i(strap[3]),
        .negotiation_enable_strap_i(strap[2]), .rate_select_strap_i(strap[1]),
        .duplex_select_strap_i(strap[0]), .hw_control_strap_i(hw), .mgmt_wr_i(wr),
        .mgmt_wr_sel_i(sel), .mgmt_wdata_i(wd), .status_rd_i(rd), .rx_page_valid_i(pv),
        .rx_page_i(rxp), .nlp_detect_i(nlp), .symbol_valid_i(idle), .symbol_idle_i(idle),
        .descrambler_lock_i(dlock), .link10_good_i(l10), .ctl_reg_o(ctl), .adv_reg_o(adv),
        .np_tx_reg_o(), .lp_base_o(lpb), .lp_next_o(), .page_rcvd_o(pg), .lp_np_able_o(),
        .base_page_o(bp), .page_rcvd_ext_o(), .fiber_mode_o(fib), .link_up_o(up),
        .speed_100_o(s100), .full_duplex_o(fd), .aneg_done_o(done), .parallel_det_o(par),
        .flp_pulse_o());
    link_partner link_partner_i (.clk_sys_i, .send_i(send), .copies_i(copies), .word_i(word),
        .lock_i(lock), .page_valid_o(pv), .page_o(rxp), .lock_o(dlock), .idle_o(idle));
    initial forever #5 clk_sys_i = ~clk_sys_i;
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask : cyc
    task automatic boot(input logic [4:0] b);
        @(posedge clk_sys_i);
        nrst_i <= 1'h0;
        {hw, strap} <= b;
        cyc(6);
        nrst_i <= 1'h1;
        cyc(14);
    endtask : boot
    task automatic mwrite(input logic [1:0] s, input logic [15:0] d);
        @(posedge clk_sys_i);
        {wr, sel, wd} <= {1'h1, s, d};
        cyc(1);
        wr <= 1'h0;
        cyc(4);
        @(negedge clk_sys_i);
    endtask : mwrite
    task automatic pages(input logic [1:0] c, input logic [15:0] w);
        @(posedge clk_sys_i);
        {send, copies, word} <= {1'h1, c, w};
        cyc(1);
        send <= 1'h0;
        cyc(10);
        @(negedge clk_sys_i);
    endtask : pages
    task automatic t_straps;
        logic [19:0] tbl [10] = '{20'h0bfcf, 20'h1bfdf, 20'hfaf2f, 20'heaf2c, 20'hdaf23,
            20'hcaf25, 20'hbff5f, 20'haff4f, 20'h9ff1f, 20'h8ff0f};
        foreach (tbl[i])
        begin
            boot({1'h0, tbl[i][19:16]});
            @(negedge clk_sys_i);
            check("mode", 16'({fib, ctl[13], ctl[12], ctl[8], adv[8:5]} & tbl[i][15:8]),
                16'(tbl[i][7:0] & tbl[i][15:8]));
        end
        @(posedge clk_sys_i) strap <= 4'h0;
        cyc(6);
        check("fiber", 16'(fib), 16'h0000);
    endtask : t_straps
    task automatic t_mgmt;
        boot(5'h0f);
        mwrite(MGMT_SEL_ADV, 16'h0021);
        check("adv", adv, 16'h0021);
        mwrite(MGMT_SEL_CTL, 16'h8000);
        check("adv", adv, 16'h01e1);
        boot(5'h1f);
        mwrite(MGMT_SEL_ADV, 16'h0021);
        check("adv", adv, 16'h01e1);
    endtask : t_mgmt
    task automatic t_pages(input logic [15:0] w, input logic [3:0] exp);
        boot(5'h0f);
        pages(2'h2, w);
        check("page flag", 16'(pg), 16'h0001);
        check("base flag", 16'(bp), 16'h0001);
        check("base", lpb, 16'h0000);
        pages(2'h1, w);
        check("base", lpb, w);
        @(posedge clk_sys_i);
        rd <= 1'h1;
        cyc(1);
        rd <= 1'h0;
        cyc(1);
        @(negedge clk_sys_i);
        check("page flag", 16'(pg), 16'h0000);
        pages(2'h3, w | 16'h4000);
        check("result", 16'({done, s100, fd}), 16'({1'h1, exp[1:0]}));
        if (exp[2])
        begin
            @(posedge clk_sys_i) lock <= 1'h1;
            cyc(150);
            check("link", 16'(up), 16'h0000);
            cyc(80);
            check("link", 16'(up), 16'h0001);
            lock <= 1'h0;
            cyc(250);
            check("link", 16'(up), 16'h0000);
        end
    endtask : t_pages
    task automatic t_parallel(input logic fast);
        boot(5'h0f);
        {nlp, lock, l10} <= {~fast, fast, ~fast};
        cyc(1);
        nlp <= 1'h0;
        cyc(6);
        check("parallel", 16'({par, s100, fd}), 16'({1'h1, fast, 1'h0}));
        check("link", 16'(up), 16'(!fast));
        {lock, l10} <= 2'h0;
    endtask : t_parallel
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : end_of_test
    initial
    begin
        #200000;
        mismatches++;
        end_of_test;
    end
    initial
    begin
        t_straps;
        t_mgmt;
        t_pages(16'h0041, 4'h1);
        t_pages(16'h01e1, 4'h7);
        t_parallel(1'h0);
        t_parallel(1'h1);
        end_of_test;
    end
endmodule : test_phy_strap_config_autoneg_link
